//--- logic/detector_fire_judgement.v
// fire judgement: pulse up-down counter, thresholds and alarm delay
// assumes sampled sensor values arrive from an unsynchronised front end
`timescale 1ns/1ps
`include "fire_judgement_defines.vh"
// Summary of operation
// - counter starts at zero, never negative
// - smoke at threshold adds one per tick
// - smoke below threshold subtracts two
// - temperature at threshold adds three
// - rise adds three; either heat below subtracts two; the heating condition leaves the rise out of both
// - combined sum adds one, else subtracts two
// - count of nine triggers fire judgement
// - photo variant alarms immediately at nine
// - multi variant alarms after adaptive delay
// - adaptive shortens delay by at most half, or lengthens
// - photo smoke threshold four, normal only
// - multi thresholds chosen by learning condition
// - adaptive delay capped at sixty seconds
module detector_fire_judgement #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
  input  wire         sys_clk_in,
  input  wire         reset_in,
  input  wire         clk_en_in,
  input  wire         multi_variant_in,
  input  wire [2:0]   learn_cond_in,
  input  wire [9:0]   smoke_in,
  input  wire [9:0]   temp_in,
  input  wire [9:0]   heat_rise_rate_in,
  input  wire [7:0]   base_delay_in,
  input  wire [7:0]   adaptive_excess_in,
  input  wire         adaptive_shorten_in,
  input  wire         alarm_clear_in,
  output reg          fire_alarm_out,
  output reg          judgement_out,
  output reg  [4:0]   count_out,
  output reg          delay_running_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // half of a delay, the most that shortening may remove
  function [7:0] half_of;
    input [7:0] value;
    begin
      half_of = value >> 1;
    end
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [9:0] smoke_s1_reg, smoke_s2_reg, temp_s1_reg, temp_s2_reg;
  reg [9:0] rise_s1_reg, rise_s2_reg;
  reg [2:0] cond_s1_reg, cond_s2_reg;
  reg       multi_s1_reg, multi_s2_reg, clr_s1_reg, clr_s2_reg;
  reg       short_s1_reg, short_s2_reg;
  reg [7:0] base_s1_reg, base_s2_reg, exc_s1_reg, exc_s2_reg;
  // word inputs are assumed held steady across many ticks, so bit skew is harmless
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      smoke_s1_reg <= 10'h000; smoke_s2_reg <= 10'h000;
      temp_s1_reg  <= 10'h000; temp_s2_reg  <= 10'h000;
      rise_s1_reg  <= 10'h000; rise_s2_reg  <= 10'h000;
      cond_s1_reg  <= 3'h0;    cond_s2_reg  <= 3'h0;
      multi_s1_reg <= 1'b0;    multi_s2_reg <= 1'b0;
      clr_s1_reg   <= 1'b0;    clr_s2_reg   <= 1'b0;
      short_s1_reg <= 1'b0;    short_s2_reg <= 1'b0;
      base_s1_reg  <= 8'h00;   base_s2_reg  <= 8'h00;
      exc_s1_reg   <= 8'h00;   exc_s2_reg   <= 8'h00;
    end else if (clk_en_in) begin
      smoke_s1_reg <= smoke_in;           smoke_s2_reg <= smoke_s1_reg;
      temp_s1_reg  <= temp_in;            temp_s2_reg  <= temp_s1_reg;
      rise_s1_reg  <= heat_rise_rate_in;  rise_s2_reg  <= rise_s1_reg;
      cond_s1_reg  <= learn_cond_in;      cond_s2_reg  <= cond_s1_reg;
      multi_s1_reg <= multi_variant_in;   multi_s2_reg <= multi_s1_reg;
      clr_s1_reg   <= alarm_clear_in;     clr_s2_reg   <= clr_s1_reg;
      short_s1_reg <= adaptive_shorten_in; short_s2_reg <= short_s1_reg;
      base_s1_reg  <= base_delay_in;      base_s2_reg  <= base_s1_reg;
      exc_s1_reg   <= adaptive_excess_in; exc_s2_reg   <= exc_s1_reg;
    end
  end

  // ----------------------------------------
  // one-second tick
  // ----------------------------------------
  wire tick;
  tick_divider #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .clk_en_in  (clk_en_in),
    .tick_out   (tick)
  );

  // ----------------------------------------
  // thresholds
  // ----------------------------------------
  reg [9:0] thr_smoke, thr_sum;
  reg       rise_used;
  always @* begin
    thr_smoke = `THR_SMOKE_NORMAL;
    thr_sum   = `THR_SUM_NORMAL;
    rise_used = 1'b1;
    if (!multi_s2_reg) begin
      thr_smoke = `THR_SMOKE_PHOTO;
    end else begin
      case (cond_s2_reg)
        `COND_CLEAN: begin
          thr_smoke = `THR_SMOKE_CLEAN;
          thr_sum   = `THR_SUM_CLEAN;
        end
        `COND_HEAT:  rise_used = 1'b0;
        `COND_COOK:  thr_sum   = `THR_SUM_COOK;
        default:     thr_sum   = `THR_SUM_NORMAL;
      endcase
    end
  end

  wire [11:0] sum_val = {1'b0, smoke_s2_reg, 1'b0} + {2'b00, rise_s2_reg};
  wire smoke_hi = smoke_s2_reg >= thr_smoke;
  wire temp_hi  = temp_s2_reg >= `THR_TEMP;
  wire rise_hi  = rise_used && (rise_s2_reg >= `THR_RISE);
  wire heat_lo  = !temp_hi || (rise_used && !rise_hi);
  wire sum_hi   = (sum_val >= {2'b00, thr_sum}) &&
                  (smoke_s2_reg >= `SUM_MIN_SMOKE) && (rise_s2_reg >= `SUM_MIN_RISE);

  // ----------------------------------------
  // counter update
  // ----------------------------------------
  reg [4:0] count_reg;
  reg [7:0] delta_up, delta_dn;
  reg [7:0] count_next;
  always @* begin
    delta_up = smoke_hi ? 8'h01 : 8'h00;
    delta_dn = smoke_hi ? 8'h00 : 8'h02;
    if (multi_s2_reg) begin
      // rise up three, heat low down two
      delta_up = delta_up + (temp_hi ? 8'h03 : 8'h00) + (rise_hi ? 8'h03 : 8'h00);
      delta_dn = delta_dn + (heat_lo ? 8'h02 : 8'h00);
      // combined up one or down two
      delta_up = delta_up + (sum_hi ? 8'h01 : 8'h00);
      delta_dn = delta_dn + (sum_hi ? 8'h00 : 8'h02);
    end
    if ({3'b000, count_reg} + delta_up <= delta_dn)
      count_next = 8'h00;
    else
      count_next = {3'b000, count_reg} + delta_up - delta_dn;
    if (count_next > {3'b000, `CNT_MAX})
      count_next = {3'b000, `CNT_MAX};
  end

  // ----------------------------------------
  // adaptive delay target
  // ----------------------------------------
  reg [8:0] delay_calc;
  reg [7:0] delay_target;
  always @* begin
    if (short_s2_reg)
      delay_calc = {1'b0, base_s2_reg} - {1'b0, ((exc_s2_reg > half_of(base_s2_reg)) ?
                   half_of(base_s2_reg) : exc_s2_reg)};
    else
      delay_calc = {1'b0, base_s2_reg} + {1'b0, exc_s2_reg};
    delay_target = (delay_calc > {1'b0, `DELAY_MAX_S}) ? `DELAY_MAX_S : delay_calc[7:0];
  end

  // ----------------------------------------
  // judgement and alarm
  // ----------------------------------------
  // clear outranks a tick in the same cycle: the panel owns the reset of a latched alarm
  reg [7:0] delay_reg;
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg         <= 5'h00;
      count_out         <= 5'h00;
      delay_reg         <= 8'h00;
      fire_alarm_out    <= 1'b0;
      judgement_out     <= 1'b0;
      delay_running_out <= 1'b0;
    end else if (clk_en_in) begin
      if (clr_s2_reg) begin
        fire_alarm_out    <= 1'b0;
        judgement_out     <= 1'b0;
        delay_running_out <= 1'b0;
        count_reg         <= 5'h00;
        count_out         <= 5'h00;
      end else if (tick && !judgement_out) begin
        count_reg <= count_next[4:0];
        count_out <= count_next[4:0];
        if (count_next >= {3'b000, `CNT_FIRE}) begin
          judgement_out <= 1'b1;
          if (!multi_s2_reg || delay_target == 8'h00) begin
            fire_alarm_out <= 1'b1;
          end else begin
            delay_reg         <= delay_target;
            delay_running_out <= 1'b1;
          end
        end
      end else if (tick && delay_running_out) begin
        if (delay_reg <= 8'h01) begin
          delay_running_out <= 1'b0;
          fire_alarm_out    <= 1'b1;
        end
        delay_reg <= delay_reg - 8'h01;
      end
    end
  end
endmodule // detector_fire_judgement

//--- logic/fire_judgement_defines.vh
// constants for the fire judgement block
// assumes sensor values in tenths of their unit, unsigned 10 bit
`ifndef FIRE_JUDGEMENT_DEFINES_VH
`define FIRE_JUDGEMENT_DEFINES_VH
`define CLK_FREQ_HZ        100000000
`define TICK_PERIOD_S      1
`define TICK_CYCLES        (`CLK_FREQ_HZ * `TICK_PERIOD_S)
`define CNT_W              5
`define CNT_FIRE           5'h09
`define CNT_MAX            5'h1f
`define VAL_W              10
// thresholds in tenths
`define THR_SMOKE_PHOTO    10'h028
`define THR_SMOKE_NORMAL   10'h032
`define THR_SMOKE_CLEAN    10'h025
`define THR_TEMP           10'h23a
`define THR_RISE           10'h0b4
`define THR_SUM_NORMAL     10'h078
`define THR_SUM_CLEAN      10'h064
`define THR_SUM_COOK       10'h08c
`define SUM_MIN_SMOKE      10'h019
`define SUM_MIN_RISE       10'h01e
// learning condition codes
`define COND_NORMAL        3'h0
`define COND_STEAM         3'h1
`define COND_CLEAN         3'h2
`define COND_HEAT          3'h3
`define COND_COOK          3'h4
// delay limits in seconds
`define DELAY_MAX_S        8'h3c
`endif

//--- logic/tick_divider.v
// one-second enable pulse generator
// assumes sys_clk_in at the rate named in the defines header
`timescale 1ns/1ps
`include "fire_judgement_defines.vh"
module tick_divider #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
  input  wire sys_clk_in,
  input  wire reset_in,
  input  wire clk_en_in,
  output reg  tick_out
);
  reg [31:0] count_reg;
  // ----------------------------------------
  // divider
  // ----------------------------------------
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= 32'h0000_0000;
      tick_out  <= 1'b0;
    end else if (clk_en_in) begin
      if (count_reg >= TICK_CYCLES - 32'h0000_0001) begin
        count_reg <= 32'h0000_0000;
        tick_out  <= 1'b1;
      end else begin
        count_reg <= count_reg + 32'h0000_0001;
        tick_out  <= 1'b0;
      end
    end
  end
endmodule // tick_divider

//--- verification/sensor_front_model.sv
// sensor front end model: presents sampled sensor values
// assumes the bench changes the scene only between ticks
`timescale 1ns/1ps
module sensor_front_model (
  input  wire       sys_clk_in,
  input  wire [9:0] scene_smoke_in, scene_temp_in, scene_rise_in,
  output reg  [9:0] smoke_out = 10'h000, temp_out = 10'h000, rise_out = 10'h000
);
  // one register stage, like a real sampler; the detector resynchronises anyway
  always @(posedge sys_clk_in) begin
    smoke_out <= scene_smoke_in;
    temp_out  <= scene_temp_in;
    rise_out  <= scene_rise_in;
  end
endmodule // sensor_front_model

//--- verification/fire_judgement_asserts.sv
// checker: counter, judgement and alarm relations
// assumes one clock and ticks every TICK_CYCLES clocks
`timescale 1ns/1ps
module fire_judgement_asserts #(parameter [31:0] TICK_CYCLES = 32'h0000_000a) (
  input wire       sys_clk_in, reset_in, clk_en_in, multi_variant_in, alarm_clear_in,
  input wire       fire_alarm_out, judgement_out, delay_running_out,
  input wire [4:0] count_out,
  input wire [7:0] base_delay_in
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // enabled cycles spent with the delay running; a frozen clock must not count
  logic [39:0] run_cycles;
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      run_cycles <= 40'h00_0000_0000;
    end else if (!delay_running_out) begin
      run_cycles <= 40'h00_0000_0000;
    end else if (clk_en_in) begin
      run_cycles <= run_cycles + 40'h00_0000_0001;
    end
  end
  chk_zero_start: assert property ($fell(reset_in) |-> count_out == 5'h00)
    else $error("count not zero after reset");
  chk_step_limit: assert property (count_out > $past(count_out) |->
    count_out - $past(count_out) <= (multi_variant_in ? 5'h08 : 5'h01))
    else $error("counter rose by too much in one tick");
  chk_judge_nine: assert property ($rose(judgement_out) |-> count_out >= 5'h09)
    else $error("judgement below nine");
  chk_count_frozen: assert property (judgement_out && $past(judgement_out) |->
    $stable(count_out)) else $error("counter moved during judgement");
  chk_photo_now: assert property ($rose(judgement_out) && !multi_variant_in |->
    fire_alarm_out && !delay_running_out) else $error("photo alarm late");
  chk_multi_wait: assert property ($rose(judgement_out) && multi_variant_in &&
    base_delay_in != 8'h00 |-> delay_running_out && !fire_alarm_out)
    else $error("multi alarm without delay");
  chk_delay_alarm: assert property ($fell(delay_running_out) && judgement_out |->
    fire_alarm_out) else $error("delay ended without alarm");
  chk_delay_cap: assert property (run_cycles <= 40'h00_0000_003c * TICK_CYCLES)
    else $error("delay over sixty ticks");
  chk_alarm_held: assert property ($fell(fire_alarm_out) |->
    $past(alarm_clear_in, 3)) else $error("alarm dropped without clear");
  cover property ($rose(fire_alarm_out) && !multi_variant_in);
  cover property ($rose(judgement_out) && multi_variant_in);
  cover property ($fell(delay_running_out) && judgement_out);
endmodule // fire_judgement_asserts
bind detector_fire_judgement fire_judgement_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
  .multi_variant_in(multi_variant_in),
  .alarm_clear_in(alarm_clear_in), .fire_alarm_out(fire_alarm_out),
  .judgement_out(judgement_out), .delay_running_out(delay_running_out),
  .count_out(count_out), .base_delay_in(base_delay_in));

//--- verification/detector_fire_judgement_tb_top.sv
// bench: random sensor scenes against a per-tick counter model
// assumes TICK_CYCLES of ten, so a tick every ten clocks
`timescale 1ns/1ps
`include "fire_judgement_defines.vh"
module detector_fire_judgement_tb_top;
  logic       clk = 1'b0, rst = 1'b1, multi = 1'b0, clr = 1'b0, shr = 1'b0, en = 1'b1;
  logic [2:0] cond = 3'h0;
  logic [7:0] base = 8'h00, exc = 8'h00;
  logic [9:0] sm = 10'h000, tp = 10'h000, rs = 10'h000;
  wire  [9:0] smoke, temp, rise;
  wire        alarm, judge, run;
  wire  [4:0] cnt;
  int         mismatches = 0, num_checks = 0, ecnt = 0, erem = 0, i, j;
  bit         ej = 0, ea = 0, er = 0;
  always #5 clk = ~clk;
  sensor_front_model model (.sys_clk_in(clk), .scene_smoke_in(sm), .scene_temp_in(tp),
    .scene_rise_in(rs), .smoke_out(smoke), .temp_out(temp), .rise_out(rise));
  detector_fire_judgement #(.TICK_CYCLES(32'h0000_000a)) uut (.sys_clk_in(clk),
    .reset_in(rst), .clk_en_in(en), .multi_variant_in(multi), .learn_cond_in(cond),
    .smoke_in(smoke), .temp_in(temp), .heat_rise_rate_in(rise), .base_delay_in(base),
    .adaptive_excess_in(exc), .adaptive_shorten_in(shr), .alarm_clear_in(clr),
    .fire_alarm_out(alarm), .judgement_out(judge), .count_out(cnt),
    .delay_running_out(run));
  function automatic int delta();
    int d, ts, tsum;
    ts = multi ? (cond == `COND_CLEAN ? `THR_SMOKE_CLEAN : `THR_SMOKE_NORMAL)
               : `THR_SMOKE_PHOTO;
    tsum = cond == `COND_CLEAN ? `THR_SUM_CLEAN : cond == `COND_COOK ? `THR_SUM_COOK
                                                                      : `THR_SUM_NORMAL;
    d = sm >= ts ? 1 : -2;
    if (multi) begin
      d += tp >= `THR_TEMP ? 3 : 0;
      // heating leaves the rise threshold out; the combined sum still uses the rise
      d += (cond != `COND_HEAT && rs >= `THR_RISE) ? 3 : 0;
      if (tp < `THR_TEMP || (cond != `COND_HEAT && rs < `THR_RISE)) d -= 2;
      d += (sm >= `SUM_MIN_SMOKE && rs >= `SUM_MIN_RISE && 2 * sm + rs >= tsum) ? 1 : -2;
    end
    return d;
  endfunction
  function automatic int dly();
    int d;
    d = shr ? base - (exc > base / 2 ? base / 2 : exc) : base + exc;
    return d > `DELAY_MAX_S ? `DELAY_MAX_S : d;
  endfunction
  task automatic check(input string n, input logic [4:0] e, input logic [4:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // one tick window; a clear is held across the tick so it must win
  task automatic step(input bit c);
    clr <= c;
    repeat (6) @(posedge clk);
    clr <= 1'b0;
    repeat (4) @(posedge clk);
    if (c) begin
      ecnt = 0; ej = 0; ea = 0; er = 0;
    end else if (!ej) begin
      ecnt = ecnt + delta();
      if (ecnt < 0) ecnt = 0;
      if (ecnt > 31) ecnt = 31;
      if (ecnt >= 9) begin
        ej = 1;
        erem = multi ? dly() : 0;
        ea = erem == 0;
        er = !ea;
      end
    end else if (er) begin
      erem--;
      ea = erem == 0;
      er = !ea;
    end
    check("count", ecnt[4:0], cnt);
    check("judgement", ej, judge);
    check("alarm", ea, alarm);
    check("delay", er, run);
  endtask
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(94));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (i = 0; i < 24; i++) begin
      multi <= i[0];
      cond <= i % 5;
      base <= i == 3 ? 8'h50 : i == 5 ? 8'h14 : $urandom_range(6);
      exc <= i == 5 ? 8'h0f : $urandom_range(6);
      shr <= i == 5 || $urandom_range(1);
      sm <= 10'h000;
      step(1'b1);
      for (j = 0; j < 90 && !ea; j++) begin
        if (j == 4) begin
          // a whole tick period frozen keeps the tick phase of the steps
          en <= 1'b0;
          repeat (10) @(posedge clk);
          en <= 1'b1;
          check("frozen count", ecnt[4:0], cnt);
          check("frozen delay", er, run);
        end
        // scenes 7 and 9 break the smoke and rise minimums of the combined sum
        sm <= i == 0 ? `THR_SMOKE_PHOTO : i == 7 ? 10'h014 : $urandom_range(70, 30);
        tp <= $urandom_range(640, 500);
        rs <= i == 9 ? 10'h014 : $urandom_range(240, 100);
        step(1'b0);
      end
    end
    finish_test();
  end
endmodule // detector_fire_judgement_tb_top
